// ===== core/irt_params.svh
// Constants for the infrared timer pair: offsets, bit positions, reset values
// Contract
// - Disabled short output is inverse initial bit
// - Enable: drive initial level, load low/high reload
// - Single pass: stop at zero, toggle, flag, interrupt
// - Modulo-N: toggle, reload by new level, flag
// - Reload values take effect at next load
// - Count 1 banned; 0 wraps FFh, no time-out
// - Demodulation: counting starts at first selected edge
// - Later edges capture complemented count, flag, reload
// - Demodulation zero: flag, interrupt, continue from FFh
// - Long output inverse when idle; submode forces level
// - Long enable loads upper*256+lower; zero toggles, flags
// - Long count 1 banned; 0 wraps, no time-out
// - Long demodulation: first edge captures, reloads, starts
// - Edge-ignore clear: each edge captures complement, reloads
// - Edge-ignore set: short time-out captures, no reload
// - Writing ignore 0 then 1 re-arms one edge
// - Long demodulation zero: continue FFFFh, flag, interrupt
// - Alternating: terminal count hands over between timers
// - Hardware toggles enables; flags at every terminal count
// - Submode 00 ends alternating operation
// - Mode bit: 0 transmit, 1 demodulation
// - Status flags clear only by writing one
`ifndef IRT_PARAMS_SVH
`define IRT_PARAMS_SVH
`define IRT_OFF_SHORT_CTRL 8'h00
`define IRT_OFF_SHARED_CTRL 8'h04
`define IRT_OFF_LONG_CTRL 8'h08
`define IRT_OFF_SHORT_HI 8'h0C
`define IRT_OFF_SHORT_LO 8'h10
`define IRT_OFF_LONG_UP 8'h14
`define IRT_OFF_LONG_LO 8'h18
`define IRT_OFF_SHORT_RISE 8'h1C
`define IRT_OFF_SHORT_FALL 8'h20
`define IRT_OFF_CAP_UP 8'h24
`define IRT_OFF_CAP_LO 8'h28
`define IRT_B_EN 7
`define IRT_B_SINGLE 6
`define IRT_B_TOUT 5
`define IRT_B_CAPIE 2
`define IRT_B_TOIE 1
`define IRT_B_MODE 6
`define IRT_B_SUB_HI 3
`define IRT_B_SUB_LO 2
`define IRT_B_INIT8 1
`define IRT_B_INIT16 0
`define IRT_RST_BYTE 8'h00
`define IRT_FULL8 8'hFF
`define IRT_FULL16 16'hFFFF
`define IRT_ONE8 8'h01
`define IRT_ONE16 16'h0001
`define IRT_RESP_OKAY 2'h0
`define IRT_RESP_SLVERR 2'h2
`endif

// ===== core/irt_pkg.sv
// Types shared by the infrared timer pair
package irt_pkg;
	typedef enum logic [1:0] {
		IRT_SUB_NORMAL = 2'b00,
		IRT_SUB_PINGPONG = 2'b01,
		IRT_SUB_FORCE0 = 2'b10,
		IRT_SUB_FORCE1 = 2'b11
	} irt_submode_type;
	typedef struct packed {
		logic en;
		logic single;
		logic tout;
		logic cap_ie;
		logic tout_ie;
	} irt_tctrl_type;
	typedef struct packed {
		logic mode;
		irt_submode_type sub;
		logic init8;
		logic init16;
		logic rise_flag;
		logic fall_flag;
	} irt_shared_type;
endpackage

// ===== core/irt_timer_pair.sv
// Eight and sixteen bit infrared carrier and demodulation timers with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "irt_params.svh"
module irt_timer_pair
	import irt_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// Prescaler tick and detected edges
	input wire logic COUNT_TICK_I,
	input wire logic EDGE_POS_I,
	input wire logic EDGE_NEG_I,
	// Timer outputs and interrupt requests
	output logic SHORT_TIMER_OUT_O,
	output logic LONG_TIMER_OUT_O,
	output logic SHORT_IRQ_O,
	output logic LONG_IRQ_O
);
	function automatic logic [7:0] pack_ctrl(input irt_tctrl_type t);
		pack_ctrl = {t.en, t.single, t.tout, 2'b00, t.cap_ie, t.tout_ie, 1'b0};
	endfunction

	irt_tctrl_type s_q, s_d, l_q, l_d;
	irt_shared_type sh_q, sh_d;
	logic [7:0] hi8_q, hi8_d, lo8_q, lo8_d, up16_q, up16_d, long_capture_lower_q, long_capture_lower_d;
	logic [7:0] rcap8_q, rcap8_d, fcap8_q, fcap8_d;
	logic [15:0] cap16_q, cap16_d, cnt16_q, cnt16_d;
	logic [7:0] cnt8_q, cnt8_d;
	logic out8_q, out8_d, out16_q, out16_d;
	logic run8_q, run8_d, run16_q, run16_d, arm16_q, arm16_d;
	logic pin8_q, pin16_q, irq8_q, irq8_d, irq16_q, irq16_d;
	logic aw_rdy_q, aw_rdy_d, bvalid_q, bvalid_d, ar_rdy_q, ar_rdy_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	logic wr, rd, edge_any, pp, edge16_take, hit8, hit16, start8, start16;
	logic [7:0] wd;
	logic [ADDR_W-1:0] wa;

	assign wr = aw_rdy_q & S_AXI_AWVALID_I & S_AXI_WVALID_I;
	assign rd = ar_rdy_q & S_AXI_ARVALID_I;
	assign wd = S_AXI_WDATA_I[7:0];
	assign wa = S_AXI_AWADDR_I;
	assign edge_any = EDGE_POS_I | EDGE_NEG_I;
	assign pp = ~sh_q.mode & (sh_q.sub == IRT_SUB_PINGPONG);
	assign edge16_take = sh_q.mode & l_q.en & edge_any & (~run16_q | ~l_q.single | arm16_q);
	// Terminal count is the tick that takes the counter from one to zero
	assign hit8 = COUNT_TICK_I & s_q.en & (cnt8_q == `IRT_ONE8) & (~sh_q.mode | (run8_q & ~edge_any));
	assign hit16 = COUNT_TICK_I & l_q.en & (cnt16_q == `IRT_ONE16) & (~sh_q.mode | (run16_q & ~edge16_take));
	assign start8 = (wr & S_AXI_WSTRB_I[0] & (wa == `IRT_OFF_SHORT_CTRL) & wd[`IRT_B_EN] & ~s_q.en)
		| (pp & hit16);
	assign start16 = (wr & S_AXI_WSTRB_I[0] & (wa == `IRT_OFF_LONG_CTRL) & wd[`IRT_B_EN] & ~l_q.en)
		| (pp & hit8);

	// Timer and register state
	always_comb
	begin
		logic clr_to8, clr_to16, clr_rise, clr_fall, set_rise, set_fall;
		clr_to8 = 1'b0;
		clr_to16 = 1'b0;
		clr_rise = 1'b0;
		clr_fall = 1'b0;
		set_rise = 1'b0;
		set_fall = 1'b0;
		s_d = s_q;
		l_d = l_q;
		sh_d = sh_q;
		hi8_d = hi8_q;
		lo8_d = lo8_q;
		up16_d = up16_q;
		long_capture_lower_d = long_capture_lower_q;
		rcap8_d = rcap8_q;
		fcap8_d = fcap8_q;
		cap16_d = cap16_q;
		cnt8_d = cnt8_q;
		cnt16_d = cnt16_q;
		out8_d = out8_q;
		out16_d = out16_q;
		run8_d = run8_q;
		run16_d = run16_q;
		arm16_d = arm16_q;
		irq8_d = 1'b0;
		irq16_d = 1'b0;
		if (wr && S_AXI_WSTRB_I[0])
		begin
			// Stop is immediate; a clear in the same write is still honoured
			if (wa == `IRT_OFF_SHORT_CTRL)
			begin
				s_d.en = wd[`IRT_B_EN];
				s_d.single = wd[`IRT_B_SINGLE];
				s_d.cap_ie = wd[`IRT_B_CAPIE];
				s_d.tout_ie = wd[`IRT_B_TOIE];
				clr_to8 = wd[`IRT_B_TOUT];
			end
			else if (wa == `IRT_OFF_SHARED_CTRL)
			begin
				sh_d.mode = wd[`IRT_B_MODE];
				sh_d.sub = irt_submode_type'(wd[`IRT_B_SUB_HI:`IRT_B_SUB_LO]);
				if (sh_q.mode)
				begin
					clr_rise = wd[`IRT_B_INIT8];
					clr_fall = wd[`IRT_B_INIT16];
				end
				else
				begin
					sh_d.init8 = wd[`IRT_B_INIT8];
					sh_d.init16 = wd[`IRT_B_INIT16];
				end
			end
			else if (wa == `IRT_OFF_LONG_CTRL)
			begin
				l_d.en = wd[`IRT_B_EN];
				l_d.single = wd[`IRT_B_SINGLE];
				l_d.cap_ie = wd[`IRT_B_CAPIE];
				l_d.tout_ie = wd[`IRT_B_TOIE];
				clr_to16 = wd[`IRT_B_TOUT];
				if (wd[`IRT_B_SINGLE] && !l_q.single)
				begin
					arm16_d = 1'b1;
				end
			end
			else if (wa == `IRT_OFF_SHORT_HI)
			begin
				hi8_d = wd;
			end
			else if (wa == `IRT_OFF_SHORT_LO)
			begin
				lo8_d = wd;
			end
			else if (wa == `IRT_OFF_LONG_UP)
			begin
				up16_d = wd;
			end
			else if (wa == `IRT_OFF_LONG_LO)
			begin
				long_capture_lower_d = wd;
			end
		end
		// Short timer
		if (start8)
		begin
			s_d.en = 1'b1;
			if (sh_q.mode)
			begin
				run8_d = 1'b0;
			end
			else
			begin
				out8_d = sh_q.init8;
				cnt8_d = sh_q.init8 ? hi8_q : lo8_q;
			end
		end
		else if (s_q.en && sh_q.mode)
		begin
			if (edge_any)
			begin
				if (run8_q)
				begin
					if (EDGE_POS_I)
					begin
						rcap8_d = ~cnt8_q;
						set_rise = 1'b1;
					end
					if (EDGE_NEG_I)
					begin
						fcap8_d = ~cnt8_q;
						set_fall = 1'b1;
					end
					irq8_d = s_q.cap_ie;
				end
				run8_d = 1'b1;
				cnt8_d = `IRT_FULL8;
			end
			else if (COUNT_TICK_I && run8_q)
			begin
				cnt8_d = cnt8_q - `IRT_ONE8;
				irq8_d = hit8 & s_q.tout_ie;
			end
		end
		else if (s_q.en && COUNT_TICK_I)
		begin
			cnt8_d = cnt8_q - `IRT_ONE8;
			if (hit8)
			begin
				out8_d = ~out8_q;
				irq8_d = s_q.tout_ie;
				if (pp || s_q.single)
				begin
					s_d.en = 1'b0;
				end
				else
				begin
					cnt8_d = out8_q ? lo8_q : hi8_q;
				end
			end
		end
		// Long timer
		if (start16)
		begin
			l_d.en = 1'b1;
			if (sh_q.mode)
			begin
				run16_d = 1'b0;
			end
			else
			begin
				out16_d = sh_q.init16;
				cnt16_d = {up16_q, long_capture_lower_q};
			end
		end
		else if (l_q.en && sh_q.mode)
		begin
			if (edge16_take)
			begin
				cap16_d = ~cnt16_q;
				if (run16_q)
				begin
					set_rise = set_rise | EDGE_POS_I;
					set_fall = set_fall | EDGE_NEG_I;
					irq16_d = l_q.cap_ie;
				end
				cnt16_d = `IRT_FULL16;
				run16_d = 1'b1;
				arm16_d = 1'b0;
			end
			else if (run16_q)
			begin
				if (COUNT_TICK_I)
				begin
					cnt16_d = cnt16_q - `IRT_ONE16;
				end
				irq16_d = hit16 & l_q.tout_ie;
				if (hit8 && l_q.single)
				begin
					cap16_d = ~cnt16_q;
					irq16_d = l_q.cap_ie | (hit16 & l_q.tout_ie);
				end
			end
		end
		else if (l_q.en && COUNT_TICK_I)
		begin
			cnt16_d = cnt16_q - `IRT_ONE16;
			if (hit16)
			begin
				out16_d = ~out16_q;
				irq16_d = l_q.tout_ie;
				if (pp || l_q.single)
				begin
					l_d.en = 1'b0;
				end
				else
				begin
					cnt16_d = {up16_q, long_capture_lower_q};
				end
			end
		end
		// A flag event wins over a clear in the same cycle
		s_d.tout = (s_q.tout & ~clr_to8) | hit8;
		l_d.tout = (l_q.tout & ~clr_to16) | hit16;
		sh_d.rise_flag = (sh_q.rise_flag & ~clr_rise) | set_rise;
		sh_d.fall_flag = (sh_q.fall_flag & ~clr_fall) | set_fall;
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			s_q <= '0;
			l_q <= '0;
			sh_q <= '0;
			hi8_q <= `IRT_RST_BYTE;
			lo8_q <= `IRT_RST_BYTE;
			up16_q <= `IRT_RST_BYTE;
			long_capture_lower_q <= `IRT_RST_BYTE;
			rcap8_q <= `IRT_RST_BYTE;
			fcap8_q <= `IRT_RST_BYTE;
			cap16_q <= '0;
			cnt8_q <= '0;
			cnt16_q <= '0;
			out8_q <= 1'b0;
			out16_q <= 1'b0;
			run8_q <= 1'b0;
			run16_q <= 1'b0;
			arm16_q <= 1'b0;
			irq8_q <= 1'b0;
			irq16_q <= 1'b0;
			pin8_q <= 1'b1;
			pin16_q <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
			l_q <= l_d;
			sh_q <= sh_d;
			hi8_q <= hi8_d;
			lo8_q <= lo8_d;
			up16_q <= up16_d;
			long_capture_lower_q <= long_capture_lower_d;
			rcap8_q <= rcap8_d;
			fcap8_q <= fcap8_d;
			cap16_q <= cap16_d;
			cnt8_q <= cnt8_d;
			cnt16_q <= cnt16_d;
			out8_q <= out8_d;
			out16_q <= out16_d;
			run8_q <= run8_d;
			run16_q <= run16_d;
			arm16_q <= arm16_d;
			irq8_q <= irq8_d;
			irq16_q <= irq16_d;
			// Idle level is the inverse so that enabling in transmit mode makes an edge, except on a forced long output
			pin8_q <= s_d.en ? out8_d : ~sh_d.init8;
			pin16_q <= sh_d.sub[1] ? sh_d.sub[0] : (l_d.en ? out16_d : ~sh_d.init16);
		end
	end

	// AXI4-Lite slave: one outstanding write and read, ready raised a cycle after valid
	always_comb
	begin
		aw_rdy_d = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~aw_rdy_q & ~bvalid_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ar_rdy_d = S_AXI_ARVALID_I & ~ar_rdy_q & ~rvalid_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (bvalid_q && S_AXI_BREADY_I)
		begin
			bvalid_d = 1'b0;
		end
		if (wr)
		begin
			bvalid_d = 1'b1;
			bresp_d = (wa > `IRT_OFF_LONG_LO || wa[1:0] != 2'b00) ? `IRT_RESP_SLVERR : `IRT_RESP_OKAY;
		end
		if (rvalid_q && S_AXI_RREADY_I)
		begin
			rvalid_d = 1'b0;
		end
		if (rd)
		begin
			rvalid_d = 1'b1;
			rresp_d = `IRT_RESP_OKAY;
			rdata_d = '0;
			if (S_AXI_ARADDR_I == `IRT_OFF_SHORT_CTRL)
			begin
				rdata_d[7:0] = pack_ctrl(s_q);
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_SHARED_CTRL)
			begin
				rdata_d[7:0] = {1'b0, sh_q.mode, 2'b00, sh_q.sub,
					sh_q.mode ? sh_q.rise_flag : sh_q.init8, sh_q.mode ? sh_q.fall_flag : sh_q.init16};
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_LONG_CTRL)
			begin
				rdata_d[7:0] = pack_ctrl(l_q);
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_SHORT_HI)
			begin
				rdata_d[7:0] = hi8_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_SHORT_LO)
			begin
				rdata_d[7:0] = lo8_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_LONG_UP)
			begin
				rdata_d[7:0] = up16_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_LONG_LO)
			begin
				rdata_d[7:0] = long_capture_lower_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_SHORT_RISE)
			begin
				rdata_d[7:0] = rcap8_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_SHORT_FALL)
			begin
				rdata_d[7:0] = fcap8_q;
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_CAP_UP)
			begin
				rdata_d[7:0] = cap16_q[15:8];
			end
			else if (S_AXI_ARADDR_I == `IRT_OFF_CAP_LO)
			begin
				rdata_d[7:0] = cap16_q[7:0];
			end
			else
			begin
				rresp_d = `IRT_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			aw_rdy_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `IRT_RESP_OKAY;
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `IRT_RESP_OKAY;
			rdata_q <= '0;
		end
		else
		begin
			aw_rdy_q <= aw_rdy_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			ar_rdy_q <= ar_rdy_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign S_AXI_AWREADY_O = aw_rdy_q;
	assign S_AXI_WREADY_O = aw_rdy_q;
	assign S_AXI_BVALID_O = bvalid_q;
	assign S_AXI_BRESP_O = bresp_q;
	assign S_AXI_ARREADY_O = ar_rdy_q;
	assign S_AXI_RVALID_O = rvalid_q;
	assign S_AXI_RRESP_O = rresp_q;
	assign S_AXI_RDATA_O = rdata_q;
	assign SHORT_TIMER_OUT_O = pin8_q;
	assign LONG_TIMER_OUT_O = pin16_q;
	assign SHORT_IRQ_O = irq8_q;
	assign LONG_IRQ_O = irq16_q;

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!ARST_N_I);

	chk_idle_short_out: assert property (!s_q.en |-> SHORT_TIMER_OUT_O == ~sh_q.init8)
		else $error("short output not inverse of initial bit while idle");
	chk_start_short_load: assert property (start8 && !sh_q.mode |=>
		out8_q == $past(sh_q.init8) && cnt8_q == ($past(sh_q.init8) ? $past(hi8_q) : $past(lo8_q)))
		else $error("short timer start load wrong");
	chk_single_short_stop: assert property (hit8 && !sh_q.mode && s_q.single && !start8 |=>
		!s_q.en && s_q.tout && out8_q != $past(out8_q) && SHORT_IRQ_O == $past(s_q.tout_ie))
		else $error("short single pass did not stop and flag");
	chk_modn_short_reload: assert property (hit8 && !sh_q.mode && !s_q.single && !pp |=>
		cnt8_q == (out8_q ? $past(hi8_q) : $past(lo8_q)))
		else $error("short modulo reload wrong");
	chk_zero_wrap_short: assert property (COUNT_TICK_I && s_q.en && !sh_q.mode && cnt8_q == 8'h00 && !start8 |=>
		cnt8_q == 8'hFF && !SHORT_IRQ_O)
		else $error("short wrap from zero wrong");
	chk_demod_short_wait: assert property (sh_q.mode && s_q.en && !run8_q && !edge_any && !start8 |=>
		$stable(cnt8_q))
		else $error("short timer counted before first edge");
	chk_demod_short_cap: assert property (sh_q.mode && s_q.en && run8_q && EDGE_POS_I && !start8 |=>
		rcap8_q == ~$past(cnt8_q) && cnt8_q == 8'hFF && sh_q.rise_flag)
		else $error("short rising capture wrong");
	chk_force_long_out: assert property (!sh_q.mode && sh_q.sub[1] |-> LONG_TIMER_OUT_O == sh_q.sub[0])
		else $error("long output not forced");
	chk_start_long_load: assert property (start16 && !sh_q.mode |=> cnt16_q == {$past(up16_q), $past(long_capture_lower_q)})
		else $error("long start load wrong");
	chk_ignore_long_edge: assert property (sh_q.mode && l_q.en && run16_q && l_q.single && !arm16_q && edge_any
		&& !COUNT_TICK_I && !start16 |=> $stable(cnt16_q))
		else $error("long timer reacted to ignored edge");
	chk_pingpong_handover: assert property (pp && hit8 |=> !s_q.en && l_q.en ##1 l_q.en)
		else $error("handover from short to long failed");
	chk_flag_sticky: assert property (s_q.tout && !(wr && wa == `IRT_OFF_SHORT_CTRL && wd[`IRT_B_TOUT]) |=> s_q.tout)
		else $error("short time-out flag lost without a clear");
	cov_single_pass: cover property (hit8 && !sh_q.mode && s_q.single);
	cov_demod_capture: cover property (edge16_take && run16_q);
	cov_pingpong_loop: cover property (pp && hit8 ##[1:1000] pp && hit16);
endmodule
`default_nettype wire

// ===== verif/irt_ir_partner.sv
// Prescaler tick and edge-detector pulse source facing the timer pair
`timescale 1ns/1ns
`default_nettype none
module irt_ir_partner
#(
	parameter int GAP = 1
)
(
	// Clock
	input wire logic clk_i,
	// Pulses toward the timers
	output logic tick_o,
	output logic pos_o,
	output logic neg_o
);
	initial
	begin
		tick_o = 1'b0;
		pos_o = 1'b0;
		neg_o = 1'b0;
	end
	// Slow prescaler: GAP plus one idle cycles between ticks, zero gives a tick every other cycle
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			tick_o <= 1'b1;
			@(posedge clk_i);
			tick_o <= 1'b0;
			repeat (GAP) @(posedge clk_i);
		end
	endtask
	// One detected edge, already filtered, as a single-cycle pulse
	task automatic edge_pulse(input logic rise);
		@(posedge clk_i);
		pos_o <= rise;
		neg_o <= !rise;
		@(posedge clk_i);
		pos_o <= 1'b0;
		neg_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verif/irt_timer_pair_tb.sv
// Self-checking bench for the infrared timer pair over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "irt_params.svh"
module ir_timer_pair_transmit_demod_tb;
	localparam logic [7:0] A_SC = `IRT_OFF_SHORT_CTRL;
	localparam logic [7:0] A_SH = `IRT_OFF_SHARED_CTRL;
	localparam logic [7:0] A_LC = `IRT_OFF_LONG_CTRL;
	localparam logic [7:0] A_8H = `IRT_OFF_SHORT_HI;
	localparam logic [7:0] A_8L = `IRT_OFF_SHORT_LO;
	localparam logic [7:0] A_16U = `IRT_OFF_LONG_UP;
	localparam logic [7:0] A_16L = `IRT_OFF_LONG_LO;
	localparam logic [7:0] A_RISE = `IRT_OFF_SHORT_RISE;
	localparam logic [7:0] A_FALL = `IRT_OFF_SHORT_FALL;
	localparam logic [7:0] A_CU = `IRT_OFF_CAP_UP;
	localparam logic [7:0] A_CL = `IRT_OFF_CAP_LO;
	logic clk_sys;
	logic arst_n;
	logic [7:0] aw_addr;
	logic [7:0] ar_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] r_data;
	logic [31:0] rd;
	logic [1:0] b_resp;
	logic [1:0] r_resp;
	logic [1:0] resp;
	logic aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic short_out, long_out, short_irq, long_irq;
	wire logic tick, pos, neg;
	int n_errors, checks, n_sirq, n_lirq, cyc;

	irt_timer_pair irt_timer_pair_inst (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n),
		.S_AXI_AWADDR_I(aw_addr), .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready),
		.S_AXI_WDATA_I(w_data), .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_valid), .S_AXI_WREADY_O(w_ready),
		.S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid), .S_AXI_BREADY_I(b_ready),
		.S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid), .S_AXI_ARREADY_O(ar_ready),
		.S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_valid), .S_AXI_RREADY_I(r_ready),
		.COUNT_TICK_I(tick), .EDGE_POS_I(pos), .EDGE_NEG_I(neg),
		.SHORT_TIMER_OUT_O(short_out), .LONG_TIMER_OUT_O(long_out),
		.SHORT_IRQ_O(short_irq), .LONG_IRQ_O(long_irq));

	irt_ir_partner #(.GAP(1)) irt_ir_partner_inst (.clk_i(clk_sys), .tick_o(tick), .pos_o(pos), .neg_o(neg));

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wr_s(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_sys);
		aw_addr <= a;
		// Upper lanes carry noise that the registers must ignore
		w_data <= {~d, ~d, ~d, d};
		w_strb <= s;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		while (b_valid !== 1'b1)
		begin
			@(posedge clk_sys);
			if (aw_ready === 1'b1)
				aw_valid <= 1'b0;
			if (w_ready === 1'b1)
				w_valid <= 1'b0;
		end
		resp = b_resp;
		b_ready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_s(a, d, 4'hF);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		while (r_valid !== 1'b1)
		begin
			@(posedge clk_sys);
			if (ar_ready === 1'b1)
				ar_valid <= 1'b0;
		end
		rd = r_data;
		resp = r_resp;
		r_ready <= 1'b0;
		chk(rd, e);
	endtask

	// Outputs are looked at mid-cycle so the launching edge has settled
	task automatic oc(input logic s, input logic l);
		@(negedge clk_sys);
		chk({30'h0, short_out, long_out}, {30'h0, s, l});
	endtask

	task automatic fin(input string t);
		$display("test %s finished, %0d mismatches so far", t, n_errors);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Interrupt pulse counters and the hang limit
	always @(posedge clk_sys)
	begin
		cyc++;
		if (short_irq === 1'b1)
			n_sirq++;
		if (long_irq === 1'b1)
			n_lirq++;
		if (cyc > 10000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	initial
	begin
		arst_n = 1'b0;
		{aw_addr, ar_addr, w_data} = '0;
		w_strb = 4'hF;
		{aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		oc(1'b1, 1'b1);
		for (int a = 0; a <= 'h28; a += 4)
			rc(8'(a), 32'h0);
		rc(8'h2C, 32'h0);
		chk({30'h0, resp}, {30'h0, `IRT_RESP_SLVERR});
		wr(A_CL, 8'h55);
		chk({30'h0, resp}, {30'h0, `IRT_RESP_SLVERR});
		rc(A_CL, 32'h0);
		wr_s(8'h03, 8'h55, 4'hF);
		chk({30'h0, resp}, {30'h0, `IRT_RESP_SLVERR});
		rc(8'h03, 32'h0);
		chk({30'h0, resp}, {30'h0, `IRT_RESP_SLVERR});
		fin("reset and map");
		wr(A_SH, 8'h02);
		oc(1'b0, 1'b1);
		wr(A_8H, 8'h02);
		wr(A_SC, 8'hC0);
		oc(1'b1, 1'b1);
		irt_ir_partner_inst.ticks(1);
		oc(1'b1, 1'b1);
		irt_ir_partner_inst.ticks(1);
		oc(1'b0, 1'b1);
		wr(A_SC, 8'h20);
		wr(A_SH, 8'h00);
		oc(1'b1, 1'b1);
		wr(A_8L, 8'h03);
		n_sirq = 0;
		wr(A_SC, 8'hC2);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(2);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(1);
		oc(1'b1, 1'b1);
		rc(A_SC, 32'h62);
		chk(n_sirq, 1);
		wr(A_SC, 8'h42);
		rc(A_SC, 32'h62);
		wr_s(A_SC, 8'h62, 4'hE);
		chk({30'h0, resp}, {30'h0, `IRT_RESP_OKAY});
		rc(A_SC, 32'h62);
		wr(A_SC, 8'h62);
		rc(A_SC, 32'h42);
		fin("single pass");
		wr(A_8L, 8'h02);
		wr(A_8H, 8'h04);
		wr(A_SC, 8'h80);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(2);
		oc(1'b1, 1'b1);
		wr(A_8L, 8'h03);
		irt_ir_partner_inst.ticks(3);
		oc(1'b1, 1'b1);
		irt_ir_partner_inst.ticks(1);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(2);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(1);
		oc(1'b1, 1'b1);
		rc(A_SC, 32'hA0);
		wr(A_SC, 8'h00);
		wr(A_SC, 8'h20);
		rc(A_SC, 32'h00);
		fin("modulo");
		wr(A_8L, 8'h00);
		wr(A_SC, 8'hC0);
		irt_ir_partner_inst.ticks(1);
		rc(A_SC, 32'hC0);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(255);
		oc(1'b1, 1'b1);
		rc(A_SC, 32'h60);
		wr(A_SC, 8'h20);
		fin("zero count");
		wr(A_16U, 8'h01);
		wr(A_16L, 8'h02);
		n_lirq = 0;
		wr(A_LC, 8'hC2);
		oc(1'b1, 1'b0);
		irt_ir_partner_inst.ticks(257);
		oc(1'b1, 1'b0);
		irt_ir_partner_inst.ticks(1);
		oc(1'b1, 1'b1);
		rc(A_LC, 32'h62);
		chk(n_lirq, 1);
		wr(A_LC, 8'h20);
		wr(A_SH, 8'h01);
		oc(1'b1, 1'b0);
		wr(A_SH, 8'h08);
		oc(1'b1, 1'b0);
		wr(A_SH, 8'h0C);
		oc(1'b1, 1'b1);
		fin("long timer");
		wr(A_SH, 8'h00);
		wr(A_8L, 8'h02);
		wr(A_16U, 8'h00);
		wr(A_16L, 8'h03);
		wr(A_SC, 8'h40);
		wr(A_LC, 8'h42);
		wr(A_SH, 8'h04);
		n_lirq = 0;
		wr(A_SC, 8'hC0);
		oc(1'b0, 1'b1);
		irt_ir_partner_inst.ticks(2);
		rc(A_SC, 32'h60);
		rc(A_LC, 32'hC2);
		oc(1'b1, 1'b0);
		irt_ir_partner_inst.ticks(3);
		rc(A_LC, 32'h62);
		rc(A_SC, 32'hE0);
		chk(n_lirq, 1);
		wr(A_SH, 8'h00);
		irt_ir_partner_inst.ticks(2);
		rc(A_LC, 32'h62);
		wr(A_SC, 8'h00);
		wr(A_LC, 8'h00);
		wr(A_SC, 8'h20);
		wr(A_LC, 8'h20);
		fin("alternating");
		wr(A_8H, 8'hFF);
		wr(A_8L, 8'hFF);
		wr(A_SH, 8'h40);
		n_sirq = 0;
		wr(A_SC, 8'h86);
		irt_ir_partner_inst.ticks(2);
		irt_ir_partner_inst.edge_pulse(1'b1);
		irt_ir_partner_inst.ticks(5);
		irt_ir_partner_inst.edge_pulse(1'b1);
		rc(A_RISE, 32'h05);
		irt_ir_partner_inst.ticks(3);
		irt_ir_partner_inst.edge_pulse(1'b0);
		rc(A_FALL, 32'h03);
		rc(A_SH, 32'h43);
		chk(n_sirq, 2);
		wr(A_SH, 8'h42);
		rc(A_SH, 32'h41);
		irt_ir_partner_inst.ticks(255);
		rc(A_SC, 32'hA6);
		chk(n_sirq, 3);
		wr(A_SC, 8'h00);
		wr(A_SC, 8'h20);
		wr(A_SH, 8'h43);
		fin("short demodulation");
		wr(A_16U, 8'hFF);
		wr(A_16L, 8'hFF);
		n_lirq = 0;
		wr(A_LC, 8'h84);
		irt_ir_partner_inst.edge_pulse(1'b0);
		irt_ir_partner_inst.ticks(7);
		irt_ir_partner_inst.edge_pulse(1'b1);
		rc(A_CU, 32'h00);
		rc(A_CL, 32'h07);
		chk(n_lirq, 1);
		rc(A_SH, 32'h42);
		wr(A_LC, 8'hC4);
		irt_ir_partner_inst.ticks(6);
		irt_ir_partner_inst.edge_pulse(1'b1);
		rc(A_CL, 32'h06);
		irt_ir_partner_inst.ticks(3);
		irt_ir_partner_inst.edge_pulse(1'b1);
		rc(A_CL, 32'h06);
		// Short time-out snapshots the long count while edges are ignored
		wr(A_SC, 8'h80);
		irt_ir_partner_inst.edge_pulse(1'b1);
		irt_ir_partner_inst.ticks(255);
		rc(A_CU, 32'h01);
		rc(A_CL, 32'h01);
		chk(n_lirq, 3);
		rc(A_SC, 32'hA0);
		wr(A_SC, 8'h00);
		wr(A_LC, 8'h00);
		fin("long demodulation");
		wrap_up();
	end
endmodule
`default_nettype wire
